/* File: rtl/stos_supervisor.sv */
// safe torque off supervisor top
// Operation
// RULE1: energised inputs: standby, start command runs drive
// RULE2: de-energised inputs: cut drive, enter off mode
// RULE3: leave off mode after reset and re-energise
// RULE4: de-energised input shows inhibit on display
// RULE5: active trip displayed instead of inhibit
// RULE6: relay one opens on cutoff when selector 13
// RULE7: relay two opens on cutoff when selector 13
// RULE8: channel fault trips with code 29
// RULE9: monitoring status changes within 20 ms
// RULE10: fault display and not-healthy within 20 ms
// RULE11: cutoff can never be disabled
// RULE12: restart may follow release per restart setting
// RULE13: de-energised: start ignored, inhibit kept
// RULE14: either channel low requests cutoff; disagreement faults
`timescale 1ns/1ps
module stos_supervisor
   import stos_pkg::*;
#(
   parameter int unsigned DISAGREE_CYC = DISAGREE_CYC_DEF
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       sto_in_a,
   input  wire logic       sto_in_b,
   input  wire logic       start_cmd,
   input  wire logic       stop_cmd,
   input  wire logic [1:0] start_source_select,
   input  wire logic [1:0] start_source_active,
   input  wire logic       auto_restart_en,
   input  wire logic       fault_reset,
   input  wire logic       ext_trip,
   input  wire logic [7:0] ext_trip_code,
   input  wire logic [7:0] relay_one_function_select,
   input  wire logic [7:0] relay_two_function_select,
   input  wire logic       relay_one_other,
   input  wire logic       relay_two_other,
   output logic            drive_enable,
   output logic            running,
   output logic            sto_active,
   output logic            sto_status,
   output stos_disp_t      display_mode,
   output logic [7:0]      trip_code,
   output logic            tripped,
   output logic            drive_healthy,
   output logic            relay_one_closed,
   output logic            relay_two_closed
);
   stos_chan_if chan ();

   stos_chan_mon #(
      .DISAGREE_CYC (DISAGREE_CYC)
   ) u_mon (
      .clk_sys (clk_sys),
      .rst     (rst),
      .chan_a  (sto_in_a),
      .chan_b  (sto_in_b),
      .chan    (chan)
   );

   // relay selector decode, shared by both relays
   function automatic logic relay_state(
      input logic [7:0] sel,
      input logic       sto,
      input logic       other
   );
      logic closed;
      if (sel == RELAY_SEL_STO) begin
         closed = ~sto;
      end else begin
         closed = other;
      end
      return closed;
   endfunction

   // one register process per group of state
   stos_state_t state_reg;
   stos_state_t state_next;
   logic        trip_reg;
   logic        trip_next;
   logic [7:0]  code_reg;
   logic [7:0]  code_next;
   stos_disp_t  disp_reg;
   stos_disp_t  disp_next;
   logic        start_ok;
   logic        cut;

   // relay copies, index 0 is relay one
   logic [7:0]  rl_sel   [2];
   logic        rl_other [2];
   logic        rl_reg   [2];
   logic        rl_next  [2];

   // start honoured only from the configured source, except auto restart from off mode, which takes start_cmd directly
   assign start_ok = start_cmd & (start_source_select == start_source_active);
   // no setting gates this term: cutoff cannot be turned off
   assign cut      = chan.request; // RULE11

   // trip group: set wins over clear, so a held fault never flickers
   always_comb begin
      trip_next = trip_reg;
      code_next = code_reg;
      if (chan.fault) begin
         trip_next = 1'b1; // RULE8
         code_next = TRIP_CHAN_FAULT; // RULE8
      end else if (ext_trip) begin
         trip_next = 1'b1;
         code_next = ext_trip_code;
      end else if (fault_reset) begin
         trip_next = 1'b0;
         code_next = TRIP_NONE;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trip_reg <= 1'b0;
         code_reg <= TRIP_NONE;
      end else begin
         trip_reg <= trip_next;
         code_reg <= code_next;
      end
   end

   // mode group: a pending trip blocks start and exit from off mode
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         STOS_ST_STANDBY: begin
            if (cut)
               state_next = STOS_ST_OFF; // RULE2
            else if (start_ok && !trip_reg && !stop_cmd)
               state_next = STOS_ST_RUN; // RULE1
         end
         STOS_ST_RUN: begin
            if (cut)
               state_next = STOS_ST_OFF; // RULE2
            else if (stop_cmd || trip_reg)
               state_next = STOS_ST_STANDBY;
         end
         STOS_ST_OFF: begin
            // start is ignored here until inputs return
            if (!cut && !trip_reg) begin // RULE3 RULE13
               if (auto_restart_en && start_cmd && !stop_cmd)
                  state_next = STOS_ST_RUN; // RULE12
               else
                  state_next = STOS_ST_STANDBY;
            end
         end
         default: state_next = STOS_ST_OFF;
      endcase
   end

   // reset lands in off mode: a drive must never wake up enabled
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= STOS_ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // display group: trip outranks inhibit, inhibit outranks run/stop
   always_comb begin
      if (trip_next) begin
         disp_next = STOS_DISP_TRIP; // RULE5 RULE10
      end else if (cut) begin
         disp_next = STOS_DISP_INHIBIT; // RULE4 RULE13
      end else begin
         disp_next = STOS_DISP_RUN_STOP;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         disp_reg <= STOS_DISP_INHIBIT;
      end else begin
         disp_reg <= disp_next;
      end
   end

   // relay group: a relay on selector 13 follows the cutoff request, not the mode; others follow their other input
   assign rl_sel[0]   = relay_one_function_select;
   assign rl_sel[1]   = relay_two_function_select;
   assign rl_other[0] = relay_one_other;
   assign rl_other[1] = relay_two_other;

   for (genvar g = 0; g < 2; g++) begin : g_relay
      always_comb begin
         rl_next[g] = relay_state(rl_sel[g], cut, rl_other[g]); // RULE6 RULE7
      end

      // open at reset, as off mode is the reset state
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            rl_reg[g] <= 1'b0;
         end else begin
            rl_reg[g] <= rl_next[g];
         end
      end
   end

   // drive removed combinationally on cut: no extra cycle of torque
   assign drive_enable     = (state_reg == STOS_ST_RUN) & ~cut; // RULE2
   assign running          = (state_reg == STOS_ST_RUN);
   assign sto_active       = (state_reg == STOS_ST_OFF);

   // status shows one clock after a channel drops
   assign sto_status       = cut; // RULE9

   // display and trip reporting
   assign display_mode     = disp_reg;
   assign trip_code        = code_reg;
   assign tripped          = trip_reg;
   // not-healthy follows the trip flag with no extra stage
   assign drive_healthy    = ~trip_reg; // RULE10

   // contacts: 1 is closed, 0 is open
   assign relay_one_closed = rl_reg[0];
   assign relay_two_closed = rl_reg[1];
endmodule

/* File: rtl/stos_pkg.sv */
// constants and types for the safe torque off supervisor
package stos_pkg;
   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned RESP_MS          = 20;
   // longest time rounds down; a margin of half is kept for the filter
   localparam int unsigned RESP_CYC         = (CLK_HZ / 1000) * RESP_MS;
   localparam int unsigned DISAGREE_CYC_DEF = RESP_CYC / 2;
   localparam logic [7:0]  RELAY_SEL_STO    = 8'h0d;
   localparam logic [7:0]  TRIP_NONE        = 8'h00;
   localparam logic [7:0]  TRIP_CHAN_FAULT  = 8'h1d;
   localparam int unsigned CNT_W            = 24;

   typedef enum logic [1:0] {
      STOS_DISP_RUN_STOP,
      STOS_DISP_INHIBIT,
      STOS_DISP_TRIP
   } stos_disp_t;

   typedef enum {
      STOS_ST_STANDBY,
      STOS_ST_RUN,
      STOS_ST_OFF
   } stos_state_t;
endpackage

/* File: rtl/stos_chan_if.sv */
// channel status carried from the channel monitor to the supervisor
`timescale 1ns/1ps
interface stos_chan_if;
   logic request;
   logic fault;
   modport mon (output request, output fault);
   modport sup (input request, input fault);
endinterface

/* File: rtl/stos_chan_mon.sv */
// two-channel input monitor with disagreement filter
`timescale 1ns/1ps
module stos_chan_mon
   import stos_pkg::*;
#(
   parameter int unsigned DISAGREE_CYC = DISAGREE_CYC_DEF
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic chan_a,
   input  wire logic chan_b,
   stos_chan_if.mon  chan
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             fault_reg;
   logic             fault_next;
   logic             req_reg;
   logic             req_next;

   always_comb begin
      req_next   = ~(chan_a & chan_b); // RULE14
      cnt_next   = '0;
      fault_next = fault_reg;
      if (chan_a != chan_b) begin
         if (cnt_reg >= CNT_W'(DISAGREE_CYC - 1)) begin
            fault_next = 1'b1; // RULE14
            cnt_next   = cnt_reg;
         end else begin
            cnt_next = cnt_reg + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_reg   <= '0;
         fault_reg <= 1'b0;
         req_reg   <= 1'b1;
      end else begin
         cnt_reg   <= cnt_next;
         fault_reg <= fault_next;
         req_reg   <= req_next;
      end
   end

   // fault stays until reset: a disagreeing channel cannot be trusted
   assign chan.request = req_reg;
   assign chan.fault   = fault_reg;
endmodule

/* File: test/stos_relay_model.sv */
// safety relay model driving both cutoff channels
`timescale 1ns/1ps
module stos_relay_model (
   input  wire logic clk_sys,
   input  wire logic energise,
   input  wire logic break_b,
   output logic      sto_in_a = 1'b1,
   output logic      sto_in_b = 1'b1
);
   // contacts follow the command one clock late, like a real relay
   always @(posedge clk_sys) begin
      sto_in_a <= energise;
      sto_in_b <= energise & ~break_b;
   end
endmodule

/* File: test/stos_supervisor_props.sv */
// assertions for the safe torque off supervisor
`timescale 1ns/1ps
module stos_supervisor_props
   import stos_pkg::*;
#(
   parameter int unsigned DISAGREE_CYC = DISAGREE_CYC_DEF
) (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       sto_in_a,
   input wire logic       sto_in_b,
   input wire logic [7:0] relay_one_function_select,
   input wire logic       drive_enable,
   input wire logic       sto_active,
   input wire logic       sto_status,
   input wire stos_disp_t display_mode,
   input wire logic [7:0] trip_code,
   input wire logic       tripped,
   input wire logic       drive_healthy,
   input wire logic       relay_one_closed
);
   logic [CNT_W-1:0] dis_cnt_reg;
   logic [CNT_W-1:0] dis_cnt_next;
   logic             drop;
   assign drop = ~(sto_in_a & sto_in_b);
   // counts far below wrap in any real run
   always_comb begin
      dis_cnt_next = (sto_in_a != sto_in_b) ? dis_cnt_reg + CNT_W'(1) : '0;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) dis_cnt_reg <= '0;
      else dis_cnt_reg <= dis_cnt_next;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sto_req_a: assert property (drop |=> sto_status)
      else $error("cutoff status late");
   cut_drive_a: assert property (sto_status |-> !drive_enable)
      else $error("drive enabled during cutoff");
   off_mode_a: assert property (drop ##1 drop |=> sto_active)
      else $error("off mode not entered");
   inhibit_disp_a: assert property (sto_status [*2] ##0 !tripped
      |-> display_mode == STOS_DISP_INHIBIT)
      else $error("inhibit not shown");
   trip_disp_a: assert property (tripped
      |-> display_mode == STOS_DISP_TRIP)
      else $error("trip not shown");
   relay_one_a: assert property ($past(sto_status)
      && $stable(relay_one_function_select)
      && relay_one_function_select == RELAY_SEL_STO
      |-> !relay_one_closed)
      else $error("relay one closed in cutoff");
   chan_fault_a: assert property (dis_cnt_reg == CNT_W'(DISAGREE_CYC + 1)
      |-> ##[0:4] (tripped && trip_code == TRIP_CHAN_FAULT))
      else $error("channel fault not tripped");
   healthy_a: assert property (drive_healthy == !tripped)
      else $error("healthy output wrong");
   cover property (sto_active ##1 !sto_active);
   cover property (tripped && trip_code == TRIP_CHAN_FAULT);
   cover property (drive_enable ##1 sto_status);
endmodule

bind stos_supervisor stos_supervisor_props #(
   .DISAGREE_CYC(DISAGREE_CYC)
) u_stos_supervisor_props (.clk_sys, .rst, .sto_in_a, .sto_in_b,
   .relay_one_function_select, .drive_enable, .sto_active, .sto_status,
   .display_mode, .trip_code, .tripped, .drive_healthy, .relay_one_closed);

/* File: test/test_stos_supervisor.sv */
// self-checking bench for the safe torque off supervisor
`timescale 1ns/1ps
module test_stos_supervisor
   import stos_pkg::*;
;
   logic clk_sys = 1'b0, rst = 1'b1, energise = 1'b1, break_b = 1'b0;
   logic start_cmd = 1'b0, stop_cmd = 1'b0, auto_restart_en = 1'b0;
   logic fault_reset = 1'b0, ext_trip = 1'b0;
   logic [1:0] start_source_select = 2'h1, start_source_active = 2'h1;
   logic [7:0] ext_trip_code = 8'h42;
   logic [7:0] relay_one_function_select = 8'h0d;
   logic [7:0] relay_two_function_select = 8'h0d;
   logic relay_one_other = 1'b1, relay_two_other = 1'b1;
   logic sto_in_a, sto_in_b, drive_enable, running, sto_active, sto_status;
   logic tripped, drive_healthy, relay_one_closed, relay_two_closed;
   stos_disp_t display_mode;
   logic [7:0] trip_code;
   int err_count = 0, n_compared = 0, i;
   stos_relay_model u_stos_relay_model (.clk_sys, .energise, .break_b,
      .sto_in_a, .sto_in_b);
   // short filter keeps the run brief
   stos_supervisor #(.DISAGREE_CYC(8)) u_stos_supervisor (.clk_sys, .rst,
      .sto_in_a, .sto_in_b, .start_cmd, .stop_cmd, .start_source_select,
      .start_source_active, .auto_restart_en, .fault_reset, .ext_trip,
      .ext_trip_code, .relay_one_function_select, .relay_two_function_select,
      .relay_one_other, .relay_two_other, .drive_enable, .running, .sto_active,
      .sto_status, .display_mode, .trip_code, .tripped, .drive_healthy,
      .relay_one_closed, .relay_two_closed);
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic wrap_up();
      if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t %h %h", $time, seen, exp);
      end
   endtask
   // sample at the falling edge, after every update has landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic do_reset();
      @(posedge clk_sys) rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
   endtask
   task automatic t_run_cut();
      @(posedge clk_sys) start_cmd <= 1'b1;
      tick(3);
      check(running, 1'b1);
      @(posedge clk_sys) energise <= 1'b0;
      tick(5);
      check(sto_status, 1'b1);
      check(drive_enable, 1'b0);
      check(display_mode, STOS_DISP_INHIBIT);
      check(relay_one_closed, 1'b0);
      check(relay_two_closed, 1'b0);
      @(posedge clk_sys) relay_two_function_select <= 8'h00;
      start_cmd <= 1'b0;
      energise <= 1'b1;
      tick(5);
      check(relay_two_closed, 1'b1);
      check(sto_active, 1'b0);
      check(running, 1'b0);
   endtask
   task automatic t_auto();
      @(posedge clk_sys) energise <= 1'b0;
      auto_restart_en <= 1'b1;
      tick(4);
      @(posedge clk_sys) start_cmd <= 1'b1;
      tick(5);
      check(running, 1'b0);
      check(drive_enable, 1'b0);
      check(display_mode, STOS_DISP_INHIBIT);
      @(posedge clk_sys) energise <= 1'b1;
      tick(5);
      check(running, 1'b1);
   endtask
   task automatic t_ext_trip();
      @(posedge clk_sys) energise <= 1'b0;
      start_cmd <= 1'b0;
      ext_trip <= 1'b1;
      // clear in the same cycle as a trip: the trip must win
      fault_reset <= 1'b1;
      @(posedge clk_sys) ext_trip <= 1'b0;
      fault_reset <= 1'b0;
      energise <= 1'b1;
      tick(5);
      check(sto_active, 1'b1);
      check(trip_code, 8'h42);
      check(display_mode, STOS_DISP_TRIP);
      @(posedge clk_sys) fault_reset <= 1'b1;
      @(posedge clk_sys) fault_reset <= 1'b0;
      tick(5);
      check(sto_active, 1'b0);
   endtask
   task automatic t_chan_fault();
      @(posedge clk_sys) break_b <= 1'b1;
      for (i = 0; i < 40 && tripped !== 1'b1; i++) tick(1);
      if (tripped !== 1'b1) begin
         err_count++;
         wrap_up();
      end
      tick(1);
      check(trip_code, TRIP_CHAN_FAULT);
      check(drive_healthy, 1'b0);
      check(sto_active, 1'b1);
      check(display_mode, STOS_DISP_TRIP);
      @(posedge clk_sys) break_b <= 1'b0;
      fault_reset <= 1'b1;
      tick(5);
      check(tripped, 1'b1);
      @(posedge clk_sys) fault_reset <= 1'b0;
      do_reset();
      tick(1);
      check(tripped, 1'b0);
   endtask
   task automatic t_refuse();
      @(posedge clk_sys) start_source_active <= 2'h2;
      start_cmd <= 1'b1;
      tick(4);
      check(running, 1'b0);
      @(posedge clk_sys) start_source_active <= 2'h1;
      stop_cmd <= 1'b1;
      tick(3);
      check(running, 1'b0);
      @(posedge clk_sys) stop_cmd <= 1'b0;
      tick(3);
      check(running, 1'b1);
      check(drive_enable, 1'b1);
   endtask
   initial begin
      do_reset();
      t_run_cut();
      t_auto();
      t_ext_trip();
      t_chan_fault();
      t_refuse();
      wrap_up();
   end
endmodule
